// ### upr_pkg.sv
// Constants and types for the serial channel power and pin routing block
package upr_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] ADDR_PIN_FUNC = 16'hff20;
  localparam logic [15:0] ADDR_P1_DIR   = 16'hff21;
  localparam logic [15:0] ADDR_P11_DIR  = 16'hff2b;
  localparam logic [15:0] ADDR_ISC      = 16'hff4f;
  localparam logic [15:0] ADDR_MODE     = 16'hff50;

  // ****************************************
  // Reset values, writable masks, fixed bits
  // ****************************************
  localparam logic [7:0] RST_PIN_FUNC  = 8'h00;
  localparam logic [7:0] RST_P1_DIR    = 8'hff;
  localparam logic [7:0] RST_P11_DIR   = 8'hff;
  localparam logic [7:0] RST_ISC       = 8'h00;
  localparam logic [7:0] RST_MODE      = 8'h01;
  localparam logic [7:0] MASK_PIN_FUNC = 8'h08;
  localparam logic [7:0] MASK_P1_DIR   = 8'hf0;
  localparam logic [7:0] FIX_P1_DIR    = 8'h0f;
  localparam logic [7:0] MASK_P11_DIR  = 8'h0f;
  localparam logic [7:0] FIX_P11_DIR   = 8'hf0;
  localparam logic [7:0] MASK_ISC      = 8'h3f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_OUT_SRC     = 3;
  localparam int BIT_ALT_TX_DIR  = 6;
  localparam int BIT_ALT_RX_DIR  = 5;
  localparam int BIT_MAIN_TX_DIR = 2;
  localparam int BIT_MAIN_RX_DIR = 3;
  localparam int BIT_POWER       = 7;
  localparam int BIT_TXE         = 6;
  localparam int BIT_RXE         = 5;
  localparam int BIT_PS_HI       = 4;
  localparam int BIT_PS_LO       = 3;
  localparam int BIT_CL          = 2;
  localparam int BIT_SL          = 1;
  localparam int BIT_PAIR_HI     = 5;
  localparam int BIT_PAIR_LO     = 4;
  localparam int BIT_RX_GATE     = 3;

  // Pin order on the pin vectors
  localparam int PIN_ALT_RX  = 0;
  localparam int PIN_ALT_TX  = 1;
  localparam int PIN_MAIN_TX = 2;
  localparam int PIN_MAIN_RX = 3;

  localparam logic [1:0] PAIR_MAIN = 2'b00;
  localparam logic [1:0] PAIR_ALT  = 2'b10;
  localparam logic [1:0] PAR_NONE  = 2'b00;
  localparam logic [1:0] PAR_ZERO  = 2'b01;
  localparam logic [1:0] PAR_ODD   = 2'b10;
  localparam logic [1:0] PAR_EVEN  = 2'b11;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } upr_rx_state_t;

endpackage

// ### upr_core_if.sv
// Carrier between the routing top and the serial engine
`timescale 1ns/10ps
interface upr_core_if;
  logic       power;
  logic       txe;
  logic       rxe;
  logic [1:0] ps;
  logic       cl;
  logic       sl;
  logic [7:0] divisor;
  logic       tx_write;
  logic [7:0] tx_data;
  logic       rxd;
  logic       txd;
  logic       tx_buf_full;
  logic       tx_busy;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic [1:0] rx_err;

  modport ctrl (output power, txe, rxe, ps, cl, sl, divisor, tx_write, tx_data, rxd,
                input  txd, tx_buf_full, tx_busy, rx_data, rx_valid, rx_err);
  modport core (input  power, txe, rxe, ps, cl, sl, divisor, tx_write, tx_data, rxd,
                output txd, tx_buf_full, tx_busy, rx_data, rx_valid, rx_err);
endinterface

// ### upr_core.sv
// Serial engine: transmitter and receiver with a shared bit-period divisor
`timescale 1ns/10ps
module upr_core
  import upr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and data
  upr_core_if.core bus
);

  logic                 run_rst;
  logic                 tx_rst;
  logic                 rx_rst;
  assign run_rst = rst | ~bus.power;
  assign tx_rst  = run_rst | ~bus.txe;
  assign rx_rst  = run_rst | ~bus.rxe;

  // ****************************************
  // Transmitter
  // ****************************************
  logic [7:0]  tx_buf;
  logic        tx_full;
  logic [11:0] tx_sh;
  logic [3:0]  tx_left;
  logic [7:0]  tx_cnt;
  logic [11:0] tx_frame;
  wire         has_par = bus.ps != PAR_NONE;
  wire         tx_tick = tx_cnt == bus.divisor - 8'h01;
  wire         tx_busy = tx_left != 4'h0;
  wire         tx_load = tx_full & ~tx_busy;
  wire  [7:0]  tx_d    = bus.cl ? tx_buf : {1'b0, tx_buf[6:0]};
  wire         tx_par  = (bus.ps == PAR_EVEN) ? ^tx_d : (bus.ps == PAR_ODD) ? ~^tx_d : 1'b0;
  wire  [3:0]  tx_len  = (bus.cl ? 4'ha : 4'h9) + {3'h0, has_par} + {3'h0, bus.sl};

  always_comb begin
    tx_frame = 12'hfff;
    unique case ({bus.cl, has_par})
      2'b11: tx_frame = {2'h3, tx_par, tx_d, 1'b0};
      2'b10: tx_frame = {3'h7, tx_d, 1'b0};
      2'b01: tx_frame = {3'h7, tx_par, tx_d[6:0], 1'b0};
      2'b00: tx_frame = {4'hf, tx_d[6:0], 1'b0};
    endcase
  end

  always_ff @(posedge clk) begin
    if (tx_rst) begin
      tx_buf  <= 8'h00;
      tx_full <= 1'b0;
      tx_sh   <= 12'hfff;
      tx_left <= 4'h0;
      tx_cnt  <= 8'h00;
    end else begin
      if (bus.tx_write) begin
        tx_buf  <= bus.tx_data;
        tx_full <= 1'b1;
      end else if (tx_load) begin
        tx_full <= 1'b0;
      end
      if (tx_load) begin
        tx_sh   <= tx_frame;
        tx_left <= tx_len;
        tx_cnt  <= 8'h00;
      end else if (tx_busy && tx_tick) begin
        tx_sh   <= {1'b1, tx_sh[11:1]};
        tx_left <= tx_left - 4'h1;
        tx_cnt  <= 8'h00;
      end else if (tx_busy) begin
        tx_cnt  <= tx_cnt + 8'h01;
      end
    end
  end

  assign bus.txd         = tx_sh[0];
  assign bus.tx_buf_full = tx_full;
  assign bus.tx_busy     = tx_busy;

  // ****************************************
  // Receiver, independent of the transmitter
  // ****************************************
  upr_rx_state_t rx_st;
  logic [7:0]    rx_cnt;
  logic [3:0]    rx_n;
  logic [8:0]    rx_sh;
  logic [7:0]    rx_data;
  logic          rx_valid;
  logic [1:0]    rx_err;
  wire           rx_tick = rx_cnt == bus.divisor - 8'h01;
  wire  [3:0]    rx_bits = (bus.cl ? 4'h8 : 4'h7) + {3'h0, has_par};
  wire  [8:0]    rx_al   = rx_sh >> (4'h9 - rx_bits);
  wire           rx_bad  = ((bus.ps == PAR_EVEN) & ^rx_al) | ((bus.ps == PAR_ODD) & ~^rx_al);

  always_ff @(posedge clk) begin
    if (rx_rst) begin
      rx_st    <= RX_IDLE;
      rx_cnt   <= 8'h00;
      rx_n     <= 4'h0;
      rx_sh    <= 9'h000;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      rx_err   <= 2'h0;
    end else begin
      rx_valid <= 1'b0;
      rx_cnt   <= rx_cnt + 8'h01;
      unique case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 8'h00;
          if (!bus.rxd) rx_st <= RX_START;
        end
        // Mid-bit check rejects glitches
        RX_START: if (rx_cnt == {1'b0, bus.divisor[7:1]}) begin
          rx_cnt <= 8'h00;
          rx_n   <= 4'h0;
          rx_st  <= bus.rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_tick) begin
          rx_cnt <= 8'h00;
          rx_sh  <= {bus.rxd, rx_sh[8:1]};
          rx_n   <= rx_n + 4'h1;
          if (rx_n == rx_bits - 4'h1) rx_st <= RX_STOP;
        end
        RX_STOP: if (rx_tick) begin
          rx_st    <= RX_IDLE;
          rx_valid <= 1'b1;
          rx_data  <= bus.cl ? rx_al[7:0] : {1'b0, rx_al[6:0]};
          rx_err   <= {rx_bad, ~bus.rxd};
        end
      endcase
    end
  end

  assign bus.rx_data  = rx_data;
  assign bus.rx_valid = rx_valid;
  assign bus.rx_err   = rx_err;

endmodule

// ### upr_top.sv
// Serial channel power control, mode register and pin-pair routing
`timescale 1ns/10ps
module upr_top
  import upr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register access
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // Transmit buffer and divisor
  input  wire logic        transmit_buffer_write,
  input  wire logic [7:0]  transmit_buffer,
  input  wire logic [7:0]  baud_divisor,
  // Port side functions
  input  wire logic [3:0]  port_latch,
  input  wire logic        clocked_serial_active,
  input  wire logic        clocked_serial_data_out,
  input  wire logic        other_async_tx_out,
  input  wire logic        segment_mode,
  input  wire logic        lcd_segment_a,
  input  wire logic        lcd_segment_b,
  // Pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe_n,
  output logic      [3:0]  port_pin_in,
  // Channel status
  output logic      [7:0]  receive_buffer,
  output logic             receive_valid,
  output logic      [1:0]  reception_error_status,
  output logic      [1:0]  transmission_status,
  output logic             break_clear
);

  upr_core_if cif ();

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] port1_pin_function_select;
  logic [7:0] port1_direction;
  logic [7:0] port11_direction;
  logic [7:0] input_switch_control;
  logic [7:0] serial_operation_mode;

  wire wr_pin_func = cpu_wr & (cpu_addr == ADDR_PIN_FUNC);
  wire wr_p1_dir   = cpu_wr & (cpu_addr == ADDR_P1_DIR);
  wire wr_p11_dir  = cpu_wr & (cpu_addr == ADDR_P11_DIR);
  wire wr_isc      = cpu_wr & (cpu_addr == ADDR_ISC);
  wire wr_mode     = cpu_wr & (cpu_addr == ADDR_MODE);

  always_ff @(posedge clk) begin
    if (rst) begin
      port1_pin_function_select <= RST_PIN_FUNC;
      port1_direction           <= RST_P1_DIR;
      port11_direction          <= RST_P11_DIR;
      input_switch_control      <= RST_ISC;
      serial_operation_mode     <= RST_MODE;
    end else begin
      if (wr_pin_func) port1_pin_function_select <= cpu_wdata & MASK_PIN_FUNC;
      if (wr_p1_dir) port1_direction <= (cpu_wdata & MASK_P1_DIR) | FIX_P1_DIR;
      if (wr_p11_dir) port11_direction <= (cpu_wdata & MASK_P11_DIR) | FIX_P11_DIR;
      if (wr_isc) input_switch_control <= cpu_wdata & MASK_ISC;
      if (wr_mode) serial_operation_mode <= cpu_wdata;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (cpu_addr)
      ADDR_PIN_FUNC: next_rdata = port1_pin_function_select;
      ADDR_P1_DIR:   next_rdata = port1_direction;
      ADDR_P11_DIR:  next_rdata = port11_direction;
      ADDR_ISC:      next_rdata = input_switch_control;
      ADDR_MODE:     next_rdata = serial_operation_mode;
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) cpu_rdata <= 8'h00;
    else if (cpu_rd) cpu_rdata <= next_rdata;
  end

  // ****************************************
  // Mode decode
  // ****************************************
  wire channel_power   = serial_operation_mode[BIT_POWER];
  wire transmit_enable = serial_operation_mode[BIT_TXE];
  wire receive_enable  = serial_operation_mode[BIT_RXE];
  wire tx_on = channel_power & transmit_enable;
  wire rx_on = channel_power & receive_enable;

  wire       shared_pin_output_source = port1_pin_function_select[BIT_OUT_SRC];
  wire       tx_alt_pin_direction     = port1_direction[BIT_ALT_TX_DIR];
  wire       rx_alt_pin_direction     = port1_direction[BIT_ALT_RX_DIR];
  wire       tx_main_pin_direction    = port11_direction[BIT_MAIN_TX_DIR];
  wire       rx_main_pin_direction    = port11_direction[BIT_MAIN_RX_DIR];
  wire [1:0] pin_pair_select          = input_switch_control[BIT_PAIR_HI:BIT_PAIR_LO];
  wire       main_rx_input_gate       = input_switch_control[BIT_RX_GATE];

  wire pair_alt  = pin_pair_select == PAIR_ALT;
  wire pair_main = pin_pair_select == PAIR_MAIN;

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
        end else begin
          pin_meta[gi] <= pin_in[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  wire main_rx_level = pin_sync[PIN_MAIN_RX] | ~main_rx_input_gate;

  // ****************************************
  // Channel routing
  // ****************************************
  // alternate pair conditions
  wire ch_tx_alt  = pair_alt & tx_on & ~tx_alt_pin_direction;
  wire ch_rx_alt  = pair_alt & rx_on & rx_alt_pin_direction;
  // main pins idle when alternate chosen
  wire ch_tx_main = pair_main & tx_on & ~tx_main_pin_direction & port_latch[PIN_MAIN_TX];
  wire ch_rx_main = pair_main & rx_on & rx_main_pin_direction;

  wire core_rxd = ch_rx_alt  ? pin_sync[PIN_ALT_RX] :
                  ch_rx_main ? main_rx_level : 1'b1;

  // ****************************************
  // Engine
  // ****************************************
  assign cif.power    = channel_power;
  assign cif.txe      = transmit_enable;
  assign cif.rxe      = receive_enable;
  assign cif.ps       = serial_operation_mode[BIT_PS_HI:BIT_PS_LO];
  assign cif.cl       = serial_operation_mode[BIT_CL];
  assign cif.sl       = serial_operation_mode[BIT_SL];
  assign cif.divisor  = baud_divisor;
  assign cif.tx_write = transmit_buffer_write & tx_on;
  assign cif.tx_data  = transmit_buffer;
  assign cif.rxd      = core_rxd;

  upr_core u_core (
    .clk (clk),
    .rst (rst),
    .bus (cif.core)
  );

  // ****************************************
  // Pin drivers
  // ****************************************
  logic [3:0] next_pin_out;
  logic [3:0] next_pin_oe_n;

  // Low enable means the pin is driven
  always_comb begin
    next_pin_out  = port_latch;
    next_pin_oe_n = 4'hf;
    next_pin_oe_n[PIN_ALT_RX] = rx_alt_pin_direction;
    if (ch_tx_alt) next_pin_out[PIN_ALT_TX] = cif.txd;
    else if (shared_pin_output_source) next_pin_out[PIN_ALT_TX] = other_async_tx_out;
    else if (clocked_serial_active) next_pin_out[PIN_ALT_TX] = clocked_serial_data_out;
    next_pin_oe_n[PIN_ALT_TX] = tx_alt_pin_direction;
    if (ch_tx_main) begin
      next_pin_out[PIN_MAIN_TX]  = cif.txd;
      next_pin_oe_n[PIN_MAIN_TX] = 1'b0;
    end else if (segment_mode) begin
      next_pin_out[PIN_MAIN_TX]  = lcd_segment_a;
      next_pin_oe_n[PIN_MAIN_TX] = 1'b0;
    end else begin
      next_pin_oe_n[PIN_MAIN_TX] = tx_main_pin_direction;
    end
    if (!ch_rx_main && segment_mode) begin
      next_pin_out[PIN_MAIN_RX]  = lcd_segment_b;
      next_pin_oe_n[PIN_MAIN_RX] = 1'b0;
    end else begin
      next_pin_oe_n[PIN_MAIN_RX] = rx_main_pin_direction;
    end
  end

  logic [3:0] next_port_pin_in;
  always_comb begin
    next_port_pin_in = pin_sync;
    next_port_pin_in[PIN_MAIN_RX] = main_rx_level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out     <= 4'hf;
      pin_oe_n    <= 4'hf;
      port_pin_in <= 4'hf;
    end else begin
      pin_out     <= next_pin_out;
      pin_oe_n    <= next_pin_oe_n;
      port_pin_in <= next_port_pin_in;
    end
  end

  // ****************************************
  // Status, cleared by power off
  // ****************************************
  // power off clears status
  always_ff @(posedge clk) begin
    if (rst || !channel_power) begin
      receive_buffer         <= 8'h00;
      receive_valid          <= 1'b0;
      reception_error_status <= 2'h0;
      transmission_status    <= 2'h0;
      break_clear            <= 1'b1;
    end else begin
      receive_valid       <= cif.rx_valid;
      transmission_status <= {cif.tx_buf_full, cif.tx_busy};
      break_clear         <= 1'b0;
      if (cif.rx_valid) begin
        receive_buffer         <= cif.rx_data;
        reception_error_status <= cif.rx_err;
      end
    end
  end

endmodule

// ### upr_checker.sv
// Port-level assertions for the serial channel routing block
`timescale 1ns/10ps
module upr_checker
  import upr_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register access
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata,
  // Channel status
  input wire logic        receive_valid,
  input wire logic [1:0]  reception_error_status,
  input wire logic [1:0]  transmission_status,
  input wire logic        break_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic mapped;
  assign mapped = cpu_addr == ADDR_PIN_FUNC || cpu_addr == ADDR_P1_DIR ||
                  cpu_addr == ADDR_P11_DIR || cpu_addr == ADDR_ISC || cpu_addr == ADDR_MODE;

  sequence mode_wr_s;
    cpu_wr && cpu_addr == ADDR_MODE;
  endsequence
  sequence mode_rd_s;
    cpu_rd && !cpu_wr && cpu_addr == ADDR_MODE;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  unmapped_read_a:
    assert property (cpu_rd && !mapped |=> cpu_rdata == 8'h00) else $error("unmapped read");
  func_reserved_a:
    assert property (cpu_rd && cpu_addr == ADDR_PIN_FUNC |=> (cpu_rdata & 8'hf7) == 8'h00)
    else $error("function register reserved bits set");
  p1_fixed_a:
    assert property (cpu_rd && cpu_addr == ADDR_P1_DIR |=> cpu_rdata[3:0] == 4'hf)
    else $error("port 1 fixed bits lost");
  p11_fixed_a:
    assert property (cpu_rd && cpu_addr == ADDR_P11_DIR |=> cpu_rdata[7:4] == 4'hf)
    else $error("port 11 fixed bits lost");
  mode_readback_a:
    assert property (mode_wr_s ##1 mode_rd_s |=> cpu_rdata == $past(cpu_wdata, 2))
    else $error("mode register readback wrong");
  rdata_hold_a:
    assert property (!cpu_rd |=> $stable(cpu_rdata)) else $error("read data moved");
  rx_pulse_a:
    assert property (receive_valid |=> !receive_valid) else $error("receive valid too long");
  off_status_a:
    assert property (break_clear [*4] |-> transmission_status == 2'b00 &&
                     reception_error_status == 2'b00) else $error("status kept at power off");
endmodule

bind upr_top upr_checker upr_checker_inst (.clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd,
  .cpu_wdata, .cpu_rdata, .receive_valid, .reception_error_status, .transmission_status,
  .break_clear);

// ### upr_partner.sv
// Remote asynchronous transceiver on the channel's serial pins
`timescale 1ns/10ps
module upr_partner (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic line_in,
  output logic     line_out
);
  // Idle mark level between frames
  initial line_out = 1'b1;

  task automatic send(input int div, input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      line_out = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (div - 1) @(negedge clk);
    end
  endtask

  task automatic recv(input int div, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line_in !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n < 600) begin
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        b[i] = line_in;
      end
      repeat (div) @(posedge clk);
      ok = (line_in === 1'b1);
    end
  endtask
endmodule

// ### tb.sv
// Self-checking bench for the serial channel routing block
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
  import upr_pkg::*;
  localparam int DIV = 16;
  logic        clk, rst, cpu_wr, cpu_rd, transmit_buffer_write, hold_n, use_alt;
  logic        clocked_serial_active, clocked_serial_data_out, other_async_tx_out;
  logic        segment_mode, lcd_segment_a, lcd_segment_b, receive_valid, break_clear;
  logic        line_in, line_out;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, transmit_buffer, baud_divisor, receive_buffer;
  logic [3:0]  port_latch, pin_in, pin_out, pin_oe_n, port_pin_in;
  logic [1:0]  reception_error_status, transmission_status;
  int          num_errors = 0;
  int          n_checks = 0;

  assign pin_in = {line_out & hold_n, pin_out[2:1], line_out};
  assign line_in = use_alt ? pin_out[1] : pin_out[2];

  upr_top upr_top_inst (.clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
    .transmit_buffer_write, .transmit_buffer, .baud_divisor, .port_latch,
    .clocked_serial_active, .clocked_serial_data_out, .other_async_tx_out, .segment_mode,
    .lcd_segment_a, .lcd_segment_b, .pin_in, .pin_out, .pin_oe_n, .port_pin_in,
    .receive_buffer, .receive_valid, .reception_error_status, .transmission_status,
    .break_clear);
  upr_partner upr_partner_inst (.clk, .line_in, .line_out);

  // ****************************************
  // Bus and transfer tasks
  // ****************************************
  task report_and_stop;
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Strobes stay up between back-to-back accesses
  task wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_rd = 1'b0;
    cpu_wr = 1'b1;
    @(negedge clk);
  endtask

  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    cpu_addr = a;
    cpu_wr = 1'b0;
    cpu_rd = 1'b1;
    @(negedge clk);
    `CHK(cpu_rdata, e)
  endtask

  task idle;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    @(negedge clk);
  endtask

  task tx_write(input logic [7:0] t);
    transmit_buffer = t;
    transmit_buffer_write = 1'b1;
    @(negedge clk);
    transmit_buffer_write = 1'b0;
  endtask

  // Both directions at once, partner replying promptly
  task xfer(input logic [7:0] t, input logic [7:0] r);
    logic [7:0] b;
    bit         ok;
    int         n;
    n = 0;
    fork
      upr_partner_inst.recv(DIV, b, ok);
      upr_partner_inst.send(DIV, r);
      tx_write(t);
      while (receive_valid !== 1'b1 && n < 800) begin
        @(negedge clk);
        n++;
      end
    join
    `CHK(b, t)
    `CHK(ok, 1'b1)
    `CHK(receive_buffer, r)
    `CHK(reception_error_status, 2'b00)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rd_chk(ADDR_PIN_FUNC, 8'h00);
    rd_chk(ADDR_P1_DIR, 8'hff);
    rd_chk(ADDR_P11_DIR, 8'hff);
    rd_chk(ADDR_ISC, 8'h00);
    rd_chk(ADDR_MODE, 8'h01);
    rd_chk(16'hff30, 8'h00);
    wr(ADDR_PIN_FUNC, 8'hff);
    rd_chk(ADDR_PIN_FUNC, 8'h08);
    wr(ADDR_P1_DIR, 8'h00);
    rd_chk(ADDR_P1_DIR, 8'h0f);
    wr(ADDR_P11_DIR, 8'h00);
    rd_chk(ADDR_P11_DIR, 8'hf0);
    wr(ADDR_MODE, 8'h1f);
    rd_chk(ADDR_MODE, 8'h1f);
    wr(16'hff30, 8'hff);
    rd_chk(16'hff30, 8'h00);
    wr(ADDR_PIN_FUNC, 8'h00);
    wr(ADDR_P1_DIR, 8'hff);
    wr(ADDR_MODE, 8'h04);
    idle;
  endtask

  task t_main;
    hold_n = 1'b0;
    wr(ADDR_P11_DIR, 8'hfb);
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_MODE, 8'hc4);
    idle;
    repeat (4) @(negedge clk);
    `CHK(port_pin_in[3], 1'b1)
    `CHK(pin_out[2], 1'b0)
    wr(ADDR_ISC, 8'h08);
    idle;
    port_latch = 4'h4;
    repeat (4) @(negedge clk);
    `CHK(port_pin_in[3], 1'b0)
    `CHK(pin_oe_n[2], 1'b0)
    hold_n = 1'b1;
    repeat (4) @(negedge clk);
    wr(ADDR_MODE, 8'he4);
    idle;
    xfer(8'ha5, 8'h3c);
  endtask

  // Power dropped mid-frame on purpose, enables cleared with it
  task t_off;
    tx_write(8'h00);
    repeat (32) @(negedge clk);
    `CHK(transmission_status, 2'b01)
    wr(ADDR_MODE, 8'h04);
    idle;
    repeat (4) @(negedge clk);
    `CHK(transmission_status, 2'b00)
    `CHK(receive_buffer, 8'h00)
    `CHK(break_clear, 1'b1)
    `CHK(pin_out[2], 1'b1)
  endtask

  // Shared pin sources and segment fallback while stopped
  task t_src;
    clocked_serial_active = 1'b1;
    other_async_tx_out = 1'b1;
    segment_mode = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(pin_out[1], 1'b0)
    `CHK(pin_out[2], 1'b0)
    `CHK(pin_oe_n[2], 1'b0)
    wr(ADDR_PIN_FUNC, 8'h08);
    idle;
    repeat (3) @(negedge clk);
    `CHK(pin_out[1], 1'b1)
    wr(ADDR_PIN_FUNC, 8'h00);
    idle;
    {clocked_serial_active, other_async_tx_out, segment_mode} = 3'h0;
  endtask

  task t_alt;
    use_alt = 1'b1;
    wr(ADDR_ISC, 8'h20);
    wr(ADDR_P1_DIR, 8'hbf);
    wr(ADDR_MODE, 8'h84);
    wr(ADDR_MODE, 8'he4);
    idle;
    repeat (4) @(negedge clk);
    `CHK(pin_oe_n[1], 1'b0)
    xfer(8'h96, 8'h69);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs about 430 cycles
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end

  initial begin
    {cpu_wr, cpu_rd, transmit_buffer_write, use_alt} = 4'h0;
    {clocked_serial_active, clocked_serial_data_out, other_async_tx_out} = 3'h0;
    {segment_mode, lcd_segment_a, lcd_segment_b} = 3'h0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    transmit_buffer = 8'h00;
    baud_divisor = 8'h10;
    port_latch = 4'h0;
    hold_n = 1'b1;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_regs;
    t_main;
    t_off;
    t_src;
    t_alt;
    report_and_stop;
  end
endmodule
